/* core/hall_commutator_pkg.sv */
// constants and types for the hall sensored trapezoidal commutator
package hall_commutator_pkg;
    localparam int          POS_WIDTH        = 3;
    localparam int          PWM_PERIOD_COUNT = 1000;
    localparam int          PWM_CNT_WIDTH    = 10;
    localparam int          EDGE_CNT_WIDTH   = 32;
    localparam int          DEAD_WIDTH       = 8;
    localparam logic [7:0]  DEAD_DEFAULT     = 8'h0A;
    // position codes in (w,v,u) order
    localparam logic [2:0]  CODE_P1          = 3'h4;
    localparam logic [2:0]  CODE_P2          = 3'h6;
    localparam logic [2:0]  CODE_P3          = 3'h2;
    localparam logic [2:0]  CODE_P4          = 3'h3;
    localparam logic [2:0]  CODE_P5          = 3'h1;
    localparam logic [2:0]  CODE_P6          = 3'h5;
    // phase index within a 3-bit per-phase vector
    localparam int          PH_U             = 0;
    localparam int          PH_V             = 1;
    localparam int          PH_W             = 2;

    typedef enum logic [1:0] {
        MODE_LOW_SIDE   = 2'h0,
        MODE_HIGH_SIDE  = 2'h1,
        MODE_COMPLEMENT = 2'h2
    } pwm_mode_type;
endpackage : hall_commutator_pkg

/* core/phase_dead_time.sv */
// one inverter leg: turns requested switch states into gate drives with dead time
`timescale 1ns/1ps
module phase_dead_time
#(
    parameter int DEAD_WIDTH = 8
)
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_high_req,
    input  wire logic                  i_low_req,
    input  wire logic [DEAD_WIDTH-1:0] i_dead_cycles,
    output logic                       o_high_drive,
    output logic                       o_low_drive
);
    logic                  high_r;
    logic                  high_nxt;
    logic                  low_r;
    logic                  low_nxt;
    logic [DEAD_WIDTH-1:0] dead_cnt_r;
    logic [DEAD_WIDTH-1:0] dead_cnt_nxt;

    always_comb
    begin
        high_nxt     = high_r;
        low_nxt      = low_r;
        dead_cnt_nxt = dead_cnt_r;
        if (dead_cnt_r != '0)
        begin
            dead_cnt_nxt = dead_cnt_r - 1'b1;
        end
        // a request that drops is obeyed at once; turning on waits out the gap
        if (!i_high_req)
        begin
            high_nxt = 1'b0;
        end
        if (!i_low_req)
        begin
            low_nxt = 1'b0;
        end
        if ((high_r && !i_high_req) || (low_r && !i_low_req))
        begin
            dead_cnt_nxt = i_dead_cycles;
        end
        else if (dead_cnt_r == '0)
        begin
            // both requested is illegal; neither switch is then turned on
            if (i_high_req && !i_low_req && !low_r)
            begin
                high_nxt = 1'b1;
            end
            if (i_low_req && !i_high_req && !high_r)
            begin
                low_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            high_r     <= 1'b0;
            low_r      <= 1'b0;
            dead_cnt_r <= '0;
        end
        else
        begin
            high_r     <= high_nxt;
            low_r      <= low_nxt;
            dead_cnt_r <= dead_cnt_nxt;
        end
    end

    assign o_high_drive = high_r;
    assign o_low_drive  = low_r;
endmodule : phase_dead_time

/* core/hall_commutator.sv */
// sensored trapezoidal commutation: hall decode, edge timing, pwm and gate drive
`timescale 1ns/1ps
module hall_commutator
    import hall_commutator_pkg::*;
#(
    parameter int PWM_PERIOD = hall_commutator_pkg::PWM_PERIOD_COUNT,
    parameter int EDGE_WIDTH = hall_commutator_pkg::EDGE_CNT_WIDTH
)
(
    input  wire logic                                    i_core_clk,
    input  wire logic                                    i_reset,
    input  wire logic                                    i_hall_u,
    input  wire logic                                    i_hall_v,
    input  wire logic                                    i_hall_w,
    input  wire logic                                    i_enable,
    input  wire logic                                    i_reverse,
    input  wire hall_commutator_pkg::pwm_mode_type       i_pwm_mode,
    input  wire logic [hall_commutator_pkg::PWM_CNT_WIDTH-1:0] i_duty,
    input  wire logic [hall_commutator_pkg::DEAD_WIDTH-1:0]    i_dead_cycles,
    output logic                                         o_high_side_switch_phase_u,
    output logic                                         o_high_side_switch_phase_v,
    output logic                                         o_high_side_switch_phase_w,
    output logic                                         o_low_side_switch_phase_u,
    output logic                                         o_low_side_switch_phase_v,
    output logic                                         o_low_side_switch_phase_w,
    output logic [2:0]                                   o_position,
    output logic [2:0]                                   o_edge_source,
    output logic                                         o_edge_pulse,
    output logic [EDGE_WIDTH-1:0]                        o_edge_interval,
    output logic                                         o_sensor_fault
);
    import hall_commutator_pkg::*;

    // active high leg / active low leg per commutation state, per phase
    function automatic logic [5:0] decode_legs(input logic [2:0] code);
        logic [5:0] legs;
        legs = 6'h00;
        unique case (code)
            CODE_P1: legs = {3'b100, 3'b010};
            CODE_P2: legs = {3'b100, 3'b001};
            CODE_P3: legs = {3'b010, 3'b001};
            CODE_P4: legs = {3'b010, 3'b100};
            CODE_P5: legs = {3'b001, 3'b100};
            CODE_P6: legs = {3'b001, 3'b010};
            default: legs = 6'h00;
        endcase
        return legs;
    endfunction : decode_legs

    logic [2:0]              hall_meta_r;
    logic [2:0]              hall_sync_r;
    logic [2:0]              hall_prev_r;
    logic [2:0]              hall_prev_nxt;
    logic [2:0]              edge_src_r;
    logic [2:0]              edge_src_nxt;
    logic                    edge_pulse_r;
    logic                    edge_pulse_nxt;
    logic [EDGE_WIDTH-1:0]   interval_cnt_r;
    logic [EDGE_WIDTH-1:0]   interval_cnt_nxt;
    logic [EDGE_WIDTH-1:0]   interval_r;
    logic [EDGE_WIDTH-1:0]   interval_nxt;
    logic [5:0]              legs_r;
    logic [5:0]              legs_nxt;
    logic                    fault_r;
    logic                    fault_nxt;
    logic [PWM_CNT_WIDTH-1:0] pwm_cnt_r;
    logic [PWM_CNT_WIDTH-1:0] pwm_cnt_nxt;
    logic                    pwm_on;
    logic [2:0]              high_req;
    logic [2:0]              low_req;
    logic [2:0]              high_drive;
    logic [2:0]              low_drive;
    logic [2:0]              hall_changed;
    logic [2:0]              drive_code;

    assign hall_changed = hall_sync_r ^ hall_prev_r;

    // reverse rotation swaps which hall state drives which step: inverting the
    // code selects the state three steps away, i.e. the opposite current path
    assign drive_code = i_reverse ? ~hall_sync_r : hall_sync_r;

    always_comb
    begin
        hall_prev_nxt    = hall_sync_r;
        edge_src_nxt     = edge_src_r;
        edge_pulse_nxt   = 1'b0;
        interval_nxt     = interval_r;
        legs_nxt         = legs_r;
        fault_nxt        = fault_r;
        interval_cnt_nxt = interval_cnt_r;
        if (interval_cnt_r != '1)
        begin
            interval_cnt_nxt = interval_cnt_r + 1'b1;
        end
        if (hall_changed != 3'h0)
        begin
            // more than one bit at once breaks the gray sequence; still follows code
            edge_src_nxt     = hall_changed;
            edge_pulse_nxt   = 1'b1;
            interval_nxt     = interval_cnt_r;
            // restart at one: the next edge then reports the full elapsed count
            interval_cnt_nxt = EDGE_WIDTH'(1);
        end
        // state always follows the latest code, in whatever order the steps come
        legs_nxt  = decode_legs(drive_code);
        fault_nxt = (hall_sync_r == 3'h0) || (hall_sync_r == 3'h7);
    end

    always_comb
    begin
        pwm_cnt_nxt = (pwm_cnt_r == PWM_CNT_WIDTH'(PWM_PERIOD - 1)) ? '0 : pwm_cnt_r + 1'b1;
    end

    assign pwm_on = (pwm_cnt_r < i_duty);

    always_comb
    begin
        high_req = 3'h0;
        low_req  = 3'h0;
        if (i_enable && !fault_r)
        begin
            unique case (i_pwm_mode)
                MODE_LOW_SIDE:
                begin
                    high_req = legs_r[5:3];
                    low_req  = pwm_on ? legs_r[2:0] : 3'h0;
                end
                MODE_HIGH_SIDE:
                begin
                    high_req = pwm_on ? legs_r[5:3] : 3'h0;
                    low_req  = legs_r[2:0];
                end
                MODE_COMPLEMENT:
                begin
                    // off time: the modulated phase's low switch carries current
                    high_req = pwm_on ? legs_r[5:3] : 3'h0;
                    low_req  = legs_r[2:0] | (pwm_on ? 3'h0 : legs_r[5:3]);
                end
                default:
                begin
                    high_req = 3'h0;
                    low_req  = 3'h0;
                end
            endcase
        end
    end

    generate
        for (genvar ph = 0; ph < 3; ph++)
        begin : g_leg
            phase_dead_time #(
                .DEAD_WIDTH (DEAD_WIDTH)
            ) u_leg (
                .i_core_clk    (i_core_clk),
                .i_reset       (i_reset),
                .i_high_req    (high_req[ph]),
                .i_low_req     (low_req[ph]),
                .i_dead_cycles (i_dead_cycles),
                .o_high_drive  (high_drive[ph]),
                .o_low_drive   (low_drive[ph])
            );
        end
    endgenerate

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            hall_meta_r    <= 3'h0;
            hall_sync_r    <= 3'h0;
            hall_prev_r    <= 3'h0;
            edge_src_r     <= 3'h0;
            edge_pulse_r   <= 1'b0;
            interval_cnt_r <= '0;
            interval_r     <= '0;
            legs_r         <= 6'h00;
            fault_r        <= 1'b1;
            pwm_cnt_r      <= '0;
        end
        else
        begin
            hall_meta_r    <= {i_hall_w, i_hall_v, i_hall_u};
            hall_sync_r    <= hall_meta_r;
            hall_prev_r    <= hall_prev_nxt;
            edge_src_r     <= edge_src_nxt;
            edge_pulse_r   <= edge_pulse_nxt;
            interval_cnt_r <= interval_cnt_nxt;
            interval_r     <= interval_nxt;
            legs_r         <= legs_nxt;
            fault_r        <= fault_nxt;
            pwm_cnt_r      <= pwm_cnt_nxt;
        end
    end

    assign o_high_side_switch_phase_u = high_drive[PH_U];
    assign o_high_side_switch_phase_v = high_drive[PH_V];
    assign o_high_side_switch_phase_w = high_drive[PH_W];
    assign o_low_side_switch_phase_u  = low_drive[PH_U];
    assign o_low_side_switch_phase_v  = low_drive[PH_V];
    assign o_low_side_switch_phase_w  = low_drive[PH_W];
    assign o_position                 = hall_prev_r;
    assign o_edge_source              = edge_src_r;
    assign o_edge_pulse               = edge_pulse_r;
    assign o_edge_interval            = interval_r;
    assign o_sensor_fault             = fault_r;
endmodule : hall_commutator

/* test/hall_commutator_sva.sv */
// checker for gate safety, sensor fault and edge timing of the commutator
`timescale 1ns/1ps
module hall_commutator_sva
    import hall_commutator_pkg::*;
#(
    parameter int EDGE_WIDTH = 32
)
(
    input wire logic                  i_core_clk,
    input wire logic                  i_reset,
    input wire logic [7:0]            i_dead_cycles,
    input wire logic                  o_high_side_switch_phase_u,
    input wire logic                  o_high_side_switch_phase_v,
    input wire logic                  o_high_side_switch_phase_w,
    input wire logic                  o_low_side_switch_phase_u,
    input wire logic                  o_low_side_switch_phase_v,
    input wire logic                  o_low_side_switch_phase_w,
    input wire logic [2:0]            o_position,
    input wire logic [2:0]            o_edge_source,
    input wire logic                  o_edge_pulse,
    input wire logic [EDGE_WIDTH-1:0] o_edge_interval,
    input wire logic                  o_sensor_fault
);
    wire [2:0] hi = {o_high_side_switch_phase_w, o_high_side_switch_phase_v,
                     o_high_side_switch_phase_u};
    wire [2:0] lo = {o_low_side_switch_phase_w, o_low_side_switch_phase_v,
                     o_low_side_switch_phase_u};
    // cycles since the last edge pulse; first interval after reset is not judged
    logic [EDGE_WIDTH-1:0] gap_r, gap_nxt;
    logic                  seen_r, seen_nxt;
    always_comb
    begin
        gap_nxt  = o_edge_pulse ? EDGE_WIDTH'(1) : gap_r + 1'b1;
        seen_nxt = seen_r | o_edge_pulse;
    end
    always_ff @(posedge i_core_clk)
    begin
        gap_r  <= i_reset ? '0 : gap_nxt;
        seen_r <= i_reset ? 1'b0 : seen_nxt;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    leg_no_overlap_a: assert property ((hi & lo) == 3'h0)
        else $error("both switches of one leg on");
    one_high_a: assert property ($onehot0(hi))
        else $error("more than one high switch on");
    fault_code_a: assert property (o_sensor_fault == (o_position inside {3'h0, 3'h7}))
        else $error("fault flag does not match position code");
    fault_gates_off_a: assert property (o_sensor_fault |=> (hi | lo) == 3'h0)
        else $error("switch on while sensor fault");
    edge_pulse_a: assert property ($past(i_reset) || o_edge_pulse == (o_position != $past(o_position)))
        else $error("edge pulse does not follow position change");
    edge_source_a: assert property (o_edge_pulse && !$past(i_reset) |-> o_edge_source == (o_position ^ $past(o_position)))
        else $error("edge source wrong");
    edge_interval_a: assert property (o_edge_pulse && seen_r |-> o_edge_interval == gap_r)
        else $error("edge interval wrong");
    dead_high_low_a: assert property ($fell(hi[2]) && i_dead_cycles >= 8'h07 |-> !lo[2] [*8])
        else $error("dead time short after high off");
    dead_low_high_a: assert property ($fell(lo[2]) && i_dead_cycles >= 8'h07 |-> !hi[2] [*8])
        else $error("dead time short after low off");
    cover property (o_edge_pulse && !o_sensor_fault);
    cover property ($fell(lo[2]) ##[1:60] hi[2]);
    cover property (o_sensor_fault ##1 !o_sensor_fault);
endmodule : hall_commutator_sva

bind hall_commutator hall_commutator_sva #(.EDGE_WIDTH(EDGE_WIDTH)) u_sva
(
    .i_core_clk, .i_reset, .i_dead_cycles,
    .o_high_side_switch_phase_u, .o_high_side_switch_phase_v, .o_high_side_switch_phase_w,
    .o_low_side_switch_phase_u, .o_low_side_switch_phase_v, .o_low_side_switch_phase_w,
    .o_position, .o_edge_source, .o_edge_pulse, .o_edge_interval, .o_sensor_fault
);

/* test/hall_sensor_model.sv */
// hall sensor model: three half-period signals, one toggling per step
`timescale 1ns/1ps
module hall_sensor_model
(
    input  wire logic       i_clk,
    input  wire logic       i_step,
    input  wire logic       i_back,
    input  wire logic       i_load,
    input  wire logic [2:0] i_code,
    output logic            o_hall_u,
    output logic            o_hall_v,
    output logic            o_hall_w
);
    localparam logic [2:0] SEQ [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
    int         idx    = 0;
    logic [2:0] code_r = 3'h4;
    // a load forces any code, also invalid ones; stepping resumes the gray walk
    always @(posedge i_clk)
        if (i_load)
            code_r <= i_code;
        else if (i_step)
        begin
            idx = i_back ? (idx + 5) % 6 : (idx + 1) % 6;
            code_r <= SEQ[idx];
        end
    assign {o_hall_w, o_hall_v, o_hall_u} = code_r;
endmodule : hall_sensor_model

/* test/hall_commutator_tb_top.sv */
// self-checking bench for the hall commutator driven by a hall sensor model
`timescale 1ns/1ps
module hall_commutator_tb_top;
    import hall_commutator_pkg::*;
    logic         i_core_clk = 1'b0;
    logic         i_reset    = 1'b1;
    logic         i_enable   = 1'b0;
    logic         i_reverse  = 1'b0;
    logic         step = 1'b0, back = 1'b0, load = 1'b0;
    logic [2:0]   load_code  = 3'h0;
    pwm_mode_type i_pwm_mode = MODE_LOW_SIDE;
    logic [9:0]   i_duty     = 10'h3E8;
    logic [7:0]   i_dead_cycles = 8'h0A;
    logic         hall_u, hall_v, hall_w, o_edge_pulse, o_sensor_fault;
    logic [2:0]   o_position, o_edge_source;
    logic [31:0]  o_edge_interval;
    logic [5:0]   gates;
    int           miscompares = 0, samples_checked = 0, pulses = 0, prev_sp = 0;
    int           seed = 32'h05d3f7b6;
    int           cnt [6];

    hall_sensor_model u_hall (.i_clk(i_core_clk), .i_step(step), .i_back(back), .i_load(load),
        .i_code(load_code), .o_hall_u(hall_u), .o_hall_v(hall_v), .o_hall_w(hall_w));
    hall_commutator DUT (.i_core_clk, .i_reset, .i_hall_u(hall_u), .i_hall_v(hall_v),
        .i_hall_w(hall_w), .i_enable, .i_reverse, .i_pwm_mode, .i_duty, .i_dead_cycles,
        .o_high_side_switch_phase_u(gates[5]), .o_high_side_switch_phase_v(gates[4]),
        .o_high_side_switch_phase_w(gates[3]), .o_low_side_switch_phase_u(gates[2]),
        .o_low_side_switch_phase_v(gates[1]), .o_low_side_switch_phase_w(gates[0]),
        .o_position, .o_edge_source, .o_edge_pulse, .o_edge_interval, .o_sensor_fault);

    initial
    begin
        forever #5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk)
        pulses <= pulses + (o_edge_pulse === 1'b1);

    // gates as {hu,hv,hw,lu,lv,lw}; reverse drives the opposite current path
    function automatic logic [5:0] exp_gates(input logic [2:0] c, input logic rv);
        case (rv ? ~c : c)
            3'h4: return 6'h0A;
            3'h6: return 6'h0C;
            3'h2: return 6'h14;
            3'h3: return 6'h11;
            3'h1: return 6'h21;
            3'h5: return 6'h22;
            default: return 6'h00;
        endcase
    endfunction : exp_gates

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("Error %s expected %0h seen %0h", what, exp, got);
            miscompares++;
        end
    endtask : check

    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    // one hall change (step or forced load), then settle g cycles and judge
    task automatic do_step(input logic ld, input logic [2:0] c, input int g);
        int p0;
        p0 = pulses;
        step      <= ~ld;
        load      <= ld;
        load_code <= c;
        @(posedge i_core_clk);
        step <= 1'b0;
        load <= 1'b0;
        repeat (g - 1) @(posedge i_core_clk);
        @(negedge i_core_clk);
        check("edge pulses", 1, pulses - p0);
        check("position", {hall_w, hall_v, hall_u}, o_position);
        check("gates", exp_gates({hall_w, hall_v, hall_u}, i_reverse), gates);
        check("fault", {hall_w, hall_v, hall_u} inside {3'h0, 3'h7}, o_sensor_fault);
        if (!ld) check("source bits", 1, $countones(o_edge_source));
        if (prev_sp > 0) check("interval", prev_sp, o_edge_interval);
        prev_sp = g + 1;
        @(posedge i_core_clk);
    endtask : do_step

    // count on-cycles of each gate over one period that starts at a rise of gate sel
    task automatic measure(input int sel);
        int   i;
        logic prev;
        cnt = '{default: 0};
        i = 0;
        prev = 1'b1;
        @(negedge i_core_clk);
        while (!(gates[sel] === 1'b1 && prev === 1'b0))
        begin
            prev = gates[sel];
            @(negedge i_core_clk);
            i++;
            if (i > 1100)
            begin
                miscompares++;
                conclude();
            end
        end
        repeat (1000)
        begin
            foreach (cnt[k]) cnt[k] += gates[k];
            prev = gates[sel];
            @(negedge i_core_clk);
        end
        check("period restart", 2'b01, {prev, gates[sel]});
        @(posedge i_core_clk);
    endtask : measure

    initial
    begin
        repeat (5) @(posedge i_core_clk);
        i_reset  <= 1'b0;
        i_enable <= 1'b1;
        // power-up code differs from the reset code and gives one edge; let it pass
        repeat (8) @(posedge i_core_clk);
        for (int r = 0; r < 2; r++)
            for (int m = 0; m < 3; m++)
            begin
                i_reverse  <= r[0];
                back       <= r[0];
                i_pwm_mode <= pwm_mode_type'(m);
                repeat (6) do_step(1'b0, 3'h0, 60);
            end
        repeat (8)
        begin
            back <= 1'($random(seed));
            do_step(1'b0, 3'h0, 40 + $unsigned($random(seed)) % 400);
        end
        do_step(1'b1, 3'h0, 60);
        do_step(1'b1, 3'h7, 60);
        i_reverse <= 1'b0;
        do_step(1'b1, 3'h4, 60);
        for (int m = 0; m < 4; m++)
        begin
            i_pwm_mode <= pwm_mode_type'(m > 1 ? 2 : m);
            i_duty     <= 10'(200 + $unsigned($random(seed)) % 500);
            if (m == 3) i_dead_cycles <= 8'(12 + $unsigned($random(seed)) % 30);
            repeat (1100) @(posedge i_core_clk);
            measure(m == 0 ? 1 : 3);
            check("idle legs", 0, cnt[2] + cnt[4] + cnt[5]);
            if (m < 2)
            begin
                check("modulated on", i_duty, cnt[m == 0 ? 1 : 3]);
                check("steady on", 1000, cnt[m == 0 ? 3 : 1]);
            end
            else
            begin
                check("low v on", 1000, cnt[1]);
                check("leg w on", 1000 - 2 * (i_dead_cycles + 1), cnt[0] + cnt[3]);
                check("sync low used", 1, cnt[0] > 0);
            end
        end
        i_enable <= 1'b0;
        repeat (20) @(posedge i_core_clk);
        i_pwm_mode <= pwm_mode_type'(3);
        @(negedge i_core_clk);
        check("disabled gates", 0, gates);
        @(posedge i_core_clk);
        i_enable <= 1'b1;
        repeat (20) @(posedge i_core_clk);
        @(negedge i_core_clk);
        check("mode off gates", 0, gates);
        conclude();
    end
endmodule : hall_commutator_tb_top
